// file: hw/mer_adv_regs.v
// Advanced status/control registers of the infrared motion engine.
// Assumes engine strobes are on CLK_IN and APB master on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "mer_regs.vh"
module mer_adv_regs #(
  parameter [7:0] LOCK_STEP = 8'h04
)(
  input  wire        CLK_IN,
  input  wire        ARST_N_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [9:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  input  wire [3:0]  PSTRB_IN,
  output wire [31:0] PRDATA_OUT,
  output wire        PREADY_OUT,
  output wire        PSLVERR_OUT,
  input  wire        ENG_INIT_IN,
  input  wire        SAMPLE_VALID_IN,
  input  wire [15:0] SAMPLE_DATA_IN,
  input  wire        OUT_OF_WIN_IN,
  input  wire        MOTION_DET_IN,
  input  wire        MOTION_EXT_IN,
  input  wire        NOISE_EVT_IN,
  input  wire        TRANSIENT_EVT_IN,
  input  wire        DC_VALID_IN,
  input  wire [15:0] DC_DATA_IN,
  input  wire [15:0] CPU_SHARE_IN,
  input  wire        SLOPE_VALID_IN,
  input  wire [7:0]  SLOPE_IN,
  output wire        FAST_FILL_OUT,
  output wire        SLOPE_OK_OUT,
  output wire [2:0]  WIN_SEL_OUT,
  output wire        WIN_RSVD_OUT,
  output wire        LIMIT_UPDATE_OUT,
  output wire        DEBOUNCE_STEP_OUT,
  output wire [7:0]  AVG_DEPTH_OUT,
  output wire [7:0]  DEBOUNCE_DUR_OUT,
  output wire [6:0]  TRANSIENT_THR_OUT,
  output wire [6:0]  NOISE_THR_OUT,
  output wire        IRQ_OUT
);

  // Stored registers and combinational next-state values
  reg        refresh_q;
  reg        new_smp_q;
  reg        origin_q;
  reg        noise_q;
  reg        trans_q;
  reg [7:0]  win_ctrl_q;
  reg [15:0] cpu_share_q;
  reg [7:0]  avg_depth_q;
  reg [7:0]  deb_dur_q;
  reg [7:0]  deb_mask_q;
  reg [6:0]  trn_thr_q;
  reg [6:0]  noi_thr_q;
  reg [15:0] sample_q;
  reg [15:0] dc_q;
  reg [7:0]  shadow_q;
  reg [3:0]  irq_sts_q;
  reg [3:0]  irq_mask_q;
  reg [31:0] rdata_q;
  reg        slverr_q;
  reg        fast_fill_q;
  reg        slope_ok_q;
  reg [2:0]  win_sel_q;
  reg        win_rsvd_q;
  reg [4:0]  upd_cnt_q;
  reg [4:0]  upd_cnt_d;
  reg        upd_q;
  reg [7:0]  hist_q;
  reg [7:0]  hist_d;
  reg        deb_step_q;
  // Combinational read mux outputs
  reg [7:0]  rd_byte;
  reg        hit;

  // Bus decode; byte lanes above the lowest are ignored
  wire [7:0]  idx       = PADDR_IN[9:2];
  wire        aligned   = (PADDR_IN[1:0] == 2'h0);
  wire        setup     = PSEL_IN & ~PENABLE_IN;
  wire        access    = PSEL_IN & PENABLE_IN;
  wire        wr_en     = access & PWRITE_IN & PSTRB_IN[0] & hit & aligned;
  wire [7:0]  wb        = PWDATA_IN[7:0];
  wire        fill_now  = ENG_INIT_IN & refresh_q;
  wire [2:0]  lock_lvl  = win_ctrl_q[`MER_WIN_LOCK_LSB +: 3];
  wire [1:0]  win_size  = win_ctrl_q[`MER_WIN_SIZE_LSB +: 2];
  wire [2:0]  upd_rate  = win_ctrl_q[`MER_WIN_RATE_LSB +: 3];
  // Widened operands so the largest level times step cannot wrap
  wire [10:0] lock_min  = {8'h00, lock_lvl} * {3'h0, LOCK_STEP};
  // Period stays below 32 for every rate, so five bits suffice
  wire [4:0]  upd_per   = `MER_UPD_BASE + (`MER_UPD_STEP * {2'h0, upd_rate});
  // Event order matches the interrupt status bit positions
  wire [3:0]  irq_evt   = {SAMPLE_VALID_IN, MOTION_DET_IN, NOISE_EVT_IN, TRANSIENT_EVT_IN};

  // Read decode; unmapped indices flag an error and read zero
  always @*
  begin
    rd_byte = 8'h00;
    hit     = 1'b1;
    case (idx)
      `MER_IDX_ASC0:
        rd_byte = {3'h0, refresh_q, new_smp_q, origin_q, noise_q, trans_q};
      `MER_IDX_WIN:      rd_byte = win_ctrl_q;
      `MER_IDX_SHARE_HI: rd_byte = cpu_share_q[15:8];
      `MER_IDX_SHARE_LO: rd_byte = shadow_q;
      `MER_IDX_AVG:      rd_byte = avg_depth_q;
      `MER_IDX_DEB_DUR:  rd_byte = deb_dur_q;
      `MER_IDX_DEB_MASK: rd_byte = deb_mask_q;
      `MER_IDX_TRN_THR:  rd_byte = {1'b0, trn_thr_q};
      `MER_IDX_NOI_THR:  rd_byte = {1'b0, noi_thr_q};
      `MER_IDX_SIG_HI:   rd_byte = sample_q[15:8];
      `MER_IDX_SIG_LO:   rd_byte = shadow_q;
      `MER_IDX_DC_HI:    rd_byte = dc_q[15:8];
      `MER_IDX_DC_LO:    rd_byte = shadow_q;
      `MER_IDX_IRQ_STS:  rd_byte = {4'h0, irq_sts_q};
      `MER_IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_q};
      default:           hit = 1'b0;
    endcase
  end

  // Read data and error sampled in setup so data leaves a flop
  // Writes and faults return zero so no stale byte leaks out
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q  <= (PWRITE_IN || !hit || !aligned) ? 32'h0000_0000 : {24'h0, rd_byte};
      slverr_q <= ~(hit & aligned);
    end
  end

  // Low byte snapshot on high byte read keeps 16-bit reads coherent
  // Limitation: a low-byte read without its high byte returns stale data
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      shadow_q <= `MER_RST_BYTE;
    else if (setup && !PWRITE_IN && aligned)
    begin
      if (idx == `MER_IDX_SHARE_HI)
        shadow_q <= cpu_share_q[7:0];
      else if (idx == `MER_IDX_SIG_HI)
        shadow_q <= sample_q[7:0];
      else if (idx == `MER_IDX_DC_HI)
        shadow_q <= dc_q[7:0];
    end
  end

  // Zero wait states: every access completes in its first cycle
  assign PREADY_OUT  = access;
  assign PRDATA_OUT  = rdata_q;
  // Error shown only while the faulty access is on the bus
  assign PSLVERR_OUT = access & slverr_q;

  // Control/status 0: hardware set beats a same-cycle software clear.
  // Only bus reset touches these; engine init leaves them alone.
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      refresh_q <= 1'b0;
      new_smp_q <= 1'b0;
      origin_q  <= 1'b0;
      noise_q   <= 1'b0;
      trans_q   <= 1'b0;
    end
    else
    begin
      if (wr_en && idx == `MER_IDX_ASC0)
        refresh_q <= wb[`MER_ASC0_REFRESH];
      if (SAMPLE_VALID_IN)
        new_smp_q <= 1'b1;
      else if (wr_en && idx == `MER_IDX_ASC0)
        new_smp_q <= wb[`MER_ASC0_NEWSMP];
      // Origin has no bus write path, so it stays read-only
      if (MOTION_DET_IN)
        origin_q <= MOTION_EXT_IN;
      if (NOISE_EVT_IN)
        noise_q <= 1'b1;
      else if (wr_en && idx == `MER_IDX_ASC0)
        noise_q <= wb[`MER_ASC0_NOISE];
      if (TRANSIENT_EVT_IN)
        trans_q <= 1'b1;
      else if (wr_en && idx == `MER_IDX_ASC0)
        trans_q <= wb[`MER_ASC0_TRANSIENT];
    end
  end

  // Software-owned configuration bytes; reserved top bits not stored
  // Writes with the low strobe off never reach these
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      win_ctrl_q  <= `MER_RST_BYTE;
      avg_depth_q <= `MER_RST_BYTE;
      deb_dur_q   <= `MER_RST_BYTE;
      deb_mask_q  <= `MER_RST_BYTE;
      trn_thr_q   <= 7'h00;
      noi_thr_q   <= 7'h00;
      irq_mask_q  <= 4'h0;
    end
    else if (wr_en)
    begin
      case (idx)
        `MER_IDX_WIN:      win_ctrl_q  <= wb;
        `MER_IDX_AVG:      avg_depth_q <= wb;
        `MER_IDX_DEB_DUR:  deb_dur_q   <= wb;
        `MER_IDX_DEB_MASK: deb_mask_q  <= wb;
        `MER_IDX_TRN_THR:  trn_thr_q   <= wb[6:0];
        `MER_IDX_NOI_THR:  noi_thr_q   <= wb[6:0];
        `MER_IDX_IRQ_MASK: irq_mask_q  <= wb[3:0];
        default:           irq_mask_q  <= irq_mask_q;             // Read-only: ignored
      endcase
    end
  end

  // Engine-owned values; bus writes never reach them
  // Process rate refreshed every cycle; it is only an indicator
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      cpu_share_q <= `MER_RST_WORD;
      sample_q    <= `MER_RST_WORD;
      dc_q        <= `MER_RST_WORD;
    end
    else
    begin
      cpu_share_q <= CPU_SHARE_IN;
      if (SAMPLE_VALID_IN)
        sample_q <= SAMPLE_DATA_IN;
      if (DC_VALID_IN)
        dc_q <= DC_DATA_IN;
    end
  end

  // Interrupt status: write one to clear, new event wins
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      irq_sts_q <= 4'h0;
    else if (wr_en && idx == `MER_IDX_IRQ_STS)
      irq_sts_q <= (irq_sts_q & ~wb[3:0]) | irq_evt;
    else
      irq_sts_q <= irq_sts_q | irq_evt;
  end

  // Level output; stays high until software clears or masks
  assign IRQ_OUT = |(irq_sts_q & irq_mask_q);

  // Fast refill request when init runs with refresh set
  // Refresh bit is left set; software decides when to drop it
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      fast_fill_q <= 1'b0;
    else
      fast_fill_q <= fill_now;
  end

  // Slope gate; lock level 0 passes every slope
  // Compared at full width so level seven never wraps
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      slope_ok_q <= 1'b0;
    else
      slope_ok_q <= SLOPE_VALID_IN & ({3'h0, SLOPE_IN} >= lock_min);
  end

  // Window size decode, one-hot small/medium/large
  // Reserved code leaves every window select low
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      win_sel_q  <= 3'h0;
      win_rsvd_q <= 1'b1;                                         // Field resets to reserved code
    end
    else
    begin
      win_rsvd_q <= (win_size == `MER_WSZ_RSVD);
      case (win_size)
        `MER_WSZ_SMALL:  win_sel_q <= 3'h1;
        `MER_WSZ_MEDIUM: win_sel_q <= 3'h2;
        `MER_WSZ_LARGE:  win_sel_q <= 3'h4;
        default:         win_sel_q <= 3'h0;
      endcase
    end
  end

  // Sample counter for control-limit updates; fast fill restarts it
  always @*
  begin
    upd_cnt_d = upd_cnt_q;
    if (fill_now)
      upd_cnt_d = 5'h00;
    else if (SAMPLE_VALID_IN)
    begin
      if (upd_cnt_q + 5'h01 >= upd_per)
        upd_cnt_d = 5'h00;
      else
        upd_cnt_d = upd_cnt_q + 5'h01;
    end
  end

  // Pulse registered so consumers see a clean one-cycle strobe
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      upd_cnt_q <= 5'h00;
      upd_q     <= 1'b0;
    end
    else
    begin
      upd_cnt_q <= upd_cnt_d;
      upd_q     <= ~fill_now & SAMPLE_VALID_IN & (upd_cnt_q + 5'h01 >= upd_per);
    end
  end

  // Out-of-window history; a full masked run counts one step, then restarts
  always @*
  begin
    hist_d = hist_q;
    if (fill_now)
      hist_d = 8'h00;
    else if (SAMPLE_VALID_IN)
      hist_d = {hist_q[6:0], OUT_OF_WIN_IN};
  end

  // Run check uses the next history so the completing sample counts
  // Limitation: history is one byte, so runs beyond eight are not possible
  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      hist_q     <= 8'h00;
      deb_step_q <= 1'b0;
    end
    else if (SAMPLE_VALID_IN && !fill_now && deb_mask_q != 8'h00
             && (hist_d & deb_mask_q) == deb_mask_q)
    begin
      hist_q     <= 8'h00;
      deb_step_q <= 1'b1;
    end
    else
    begin
      hist_q     <= hist_d;
      deb_step_q <= 1'b0;
    end
  end

  assign FAST_FILL_OUT     = fast_fill_q;
  assign SLOPE_OK_OUT      = slope_ok_q;
  assign WIN_SEL_OUT       = win_sel_q;
  assign WIN_RSVD_OUT      = win_rsvd_q;
  assign LIMIT_UPDATE_OUT  = upd_q;
  assign DEBOUNCE_STEP_OUT = deb_step_q;
  assign AVG_DEPTH_OUT     = avg_depth_q;
  assign DEBOUNCE_DUR_OUT  = deb_dur_q;
  assign TRANSIENT_THR_OUT = trn_thr_q;
  assign NOISE_THR_OUT     = noi_thr_q;

endmodule // mer_adv_regs
`default_nettype wire

// file: shared/mer_regs.vh
// Constants of the motion engine advanced register block.
// Assumes an APB slave with word-aligned byte registers (index * 4).
`ifndef MER_REGS_VH
`define MER_REGS_VH
// Register indices; byte address is index * 4
`define MER_IDX_ASC0      8'hF0
`define MER_IDX_WIN       8'hF2
`define MER_IDX_SHARE_HI  8'hF3
`define MER_IDX_SHARE_LO  8'hF4
`define MER_IDX_AVG       8'hF5
`define MER_IDX_DEB_DUR   8'hF6
`define MER_IDX_DEB_MASK  8'hF7
`define MER_IDX_TRN_THR   8'hF8
`define MER_IDX_NOI_THR   8'hF9
`define MER_IDX_SIG_HI    8'hFA
`define MER_IDX_SIG_LO    8'hFB
`define MER_IDX_DC_HI     8'hFC
`define MER_IDX_DC_LO     8'hFD
`define MER_IDX_IRQ_STS   8'hE0
`define MER_IDX_IRQ_MASK  8'hE1
// Control/status register 0 fields
`define MER_ASC0_TRANSIENT 0
`define MER_ASC0_NOISE     1
`define MER_ASC0_ORIGIN    2
`define MER_ASC0_NEWSMP    3
`define MER_ASC0_REFRESH   4
// Window control fields
`define MER_WIN_RATE_LSB   0
`define MER_WIN_SIZE_LSB   3
`define MER_WIN_LOCK_LSB   5
// Window size codes
`define MER_WSZ_RSVD       2'h0
`define MER_WSZ_SMALL      2'h1
`define MER_WSZ_MEDIUM     2'h2
`define MER_WSZ_LARGE      2'h3
// Update period = base + step * rate, in samples
`define MER_UPD_BASE       5'h04
`define MER_UPD_STEP       5'h02
// Interrupt status bits
`define MER_IRQ_TRANSIENT  0
`define MER_IRQ_NOISE      1
`define MER_IRQ_MOTION     2
`define MER_IRQ_NEWSMP     3
// Bus reset value of every stored field
`define MER_RST_BYTE       8'h00
`define MER_RST_WORD       16'h0000
`endif

// file: tb/mer_adv_regs_checker.sv
// Port-level assertions for the motion engine advanced register block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module mer_adv_regs_checker (
  input wire logic       CLK_IN,
  input wire logic       ARST_N_IN,
  input wire logic       PSEL_IN,
  input wire logic       PENABLE_IN,
  input wire logic       PWRITE_IN,
  input wire logic       ENG_INIT_IN,
  input wire logic       SAMPLE_VALID_IN,
  input wire logic       MOTION_DET_IN,
  input wire logic       NOISE_EVT_IN,
  input wire logic       TRANSIENT_EVT_IN,
  input wire logic       SLOPE_VALID_IN,
  input wire logic       FAST_FILL_OUT,
  input wire logic       SLOPE_OK_OUT,
  input wire logic [2:0] WIN_SEL_OUT,
  input wire logic       WIN_RSVD_OUT,
  input wire logic       LIMIT_UPDATE_OUT,
  input wire logic       DEBOUNCE_STEP_OUT,
  input wire logic       IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Pulse outputs must trace back to their strobe one cycle earlier
  property p_fill; FAST_FILL_OUT |-> $past(ENG_INIT_IN); endproperty
  a_fill: assert property (p_fill) else $error("fill without init");
  property p_slope; SLOPE_OK_OUT |-> $past(SLOPE_VALID_IN); endproperty
  a_slope: assert property (p_slope) else $error("slope ok without slope");
  property p_lim; LIMIT_UPDATE_OUT |-> $past(SAMPLE_VALID_IN); endproperty
  a_lim: assert property (p_lim) else $error("update without sample");
  // Shortest period is four samples, so updates are never closer
  property p_gap; LIMIT_UPDATE_OUT |=> (!LIMIT_UPDATE_OUT) [*3]; endproperty
  a_gap: assert property (p_gap) else $error("updates too close");
  property p_deb; DEBOUNCE_STEP_OUT |-> $past(SAMPLE_VALID_IN); endproperty
  a_deb: assert property (p_deb) else $error("step without sample");
  // Window select is one-hot or reserved, and moves only on a write
  property p_win; $onehot0(WIN_SEL_OUT) && (WIN_RSVD_OUT == (WIN_SEL_OUT == 3'h0)); endproperty
  a_win: assert property (p_win) else $error("bad window select");
  property p_winw; !$stable(WIN_SEL_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN, 2);
  endproperty
  a_winw: assert property (p_winw) else $error("window moved unwritten");
  property p_irq; $rose(IRQ_OUT) |-> $past(SAMPLE_VALID_IN || MOTION_DET_IN ||
    NOISE_EVT_IN || TRANSIENT_EVT_IN || (PENABLE_IN && PWRITE_IN)); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule // mer_adv_regs_checker
`default_nettype wire

// file: tb/mer_sensor_model.sv
// Behavioural sensor and converter: one sample per cycle of request.
// Assumes the bench raises the request just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module mer_sensor_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        go_in,
  output var  logic        valid_out,
  output var  logic [15:0] data_out
);
  // Idle data shows the inverse so a stale capture cannot match by luck
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      valid_out <= 1'b0;
      data_out  <= 16'h3C5A;
    end
    else
    begin
      valid_out <= go_in;
      data_out  <= go_in ? data_out + 16'h1357 : ~data_out;
    end
  end
endmodule // mer_sensor_model
`default_nettype wire

// file: tb/tb_mer_adv_regs.sv
// Self-checking bench: APB register tests plus engine strobe scenarios.
// Assumes zero-or-more wait state slave and the sensor model on samples.
`timescale 1ns/10ps
`default_nettype none
module tb_mer_adv_regs;
  localparam logic [7:0] STEP = 8'h04;
  logic CLK_IN = 1'b0, ARST_N_IN = 1'b0, PSEL_IN = 1'b0, PENABLE_IN = 1'b0;
  logic PWRITE_IN = 1'b0, ENG_INIT_IN = 1'b0, OUT_OF_WIN_IN = 1'b0, go = 1'b0;
  logic MOTION_DET_IN = 1'b0, MOTION_EXT_IN = 1'b0, NOISE_EVT_IN = 1'b0;
  logic TRANSIENT_EVT_IN = 1'b0, DC_VALID_IN = 1'b0, SLOPE_VALID_IN = 1'b0;
  logic [9:0]  PADDR_IN = 10'h000;
  logic [31:0] PWDATA_IN = 32'h0, rd;
  logic [3:0]  PSTRB_IN = 4'hF;
  logic [15:0] DC_DATA_IN = 16'h0, CPU_SHARE_IN = 16'hA5C3, last_smp;
  logic [7:0]  SLOPE_IN = 8'h00;
  logic        err;
  wire logic   SAMPLE_VALID_IN, PREADY_OUT, PSLVERR_OUT, FAST_FILL_OUT, SLOPE_OK_OUT;
  wire logic   WIN_RSVD_OUT, LIMIT_UPDATE_OUT, DEBOUNCE_STEP_OUT, IRQ_OUT;
  wire logic [15:0] SAMPLE_DATA_IN;
  wire logic [31:0] PRDATA_OUT;
  wire logic [2:0]  WIN_SEL_OUT;
  wire logic [7:0]  AVG_DEPTH_OUT, DEBOUNCE_DUR_OUT;
  wire logic [6:0]  TRANSIENT_THR_OUT, NOISE_THR_OUT;
  int bad_count = 0, n_checks = 0, fill_n = 0, ok_n = 0, lim_n = 0, deb_n = 0, n;

  mer_adv_regs #(.LOCK_STEP(STEP)) dut (.*);
  mer_sensor_model u_sensor (.clk_in(CLK_IN), .rst_n_in(ARST_N_IN), .go_in(go),
    .valid_out(SAMPLE_VALID_IN), .data_out(SAMPLE_DATA_IN));

  always #2.5 CLK_IN = ~CLK_IN;
  // Pulse outputs stand one cycle, so tally them on every edge
  always @(posedge CLK_IN)
  begin
    fill_n <= fill_n + FAST_FILL_OUT;
    ok_n <= ok_n + SLOPE_OK_OUT;
    lim_n <= lim_n + LIMIT_UPDATE_OUT;
    deb_n <= deb_n + DEBOUNCE_STEP_OUT;
    if (SAMPLE_VALID_IN) last_smp <= SAMPLE_DATA_IN;
  end

  task final_report;
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; idle edge first so no signal is driven twice per step
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= {idx, 2'b00};
    PWDATA_IN <= {24'h0, d};
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    k = 0;
    do
    begin
      @(posedge CLK_IN);
      k++;
    end
    while (PREADY_OUT !== 1'b1 && k < 20);
    rd = PRDATA_OUT;
    err = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    if (PREADY_OUT !== 1'b1)
    begin
      bad_count++;
      final_report;
    end
  endtask

  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  // Request k back-to-back samples, then let the pulses land
  task smp(input int k, input logic oow);
    @(posedge CLK_IN);
    go <= 1'b1;
    OUT_OF_WIN_IN <= oow;
    repeat (k) @(posedge CLK_IN);
    go <= 1'b0;
    repeat (3) @(posedge CLK_IN);
  endtask

  task init;
    @(posedge CLK_IN);
    ENG_INIT_IN <= 1'b1;
    @(posedge CLK_IN);
    ENG_INIT_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
  endtask

  initial
  begin
    repeat (12) @(posedge CLK_IN);
    ARST_N_IN <= 1'b1;
    rdc(8'hF0, 8'h00);
    smp(1, 1'b0);
    rdc(8'hF0, 8'h08);
    rdc(8'hFA, last_smp[15:8]);
    rdc(8'hFB, last_smp[7:0]);
    apb(1'b1, 8'hF0, 8'h00);
    rdc(8'hF0, 8'h00);
    apb(1'b1, 8'hFA, ~last_smp[15:8]);
    rdc(8'hFA, last_smp[15:8]);
    apb(1'b1, 8'hF0, 8'h04);
    rdc(8'hF0, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk(err, 1'b1);
    apb(1'b1, 8'hF5, 8'h5A);
    apb(1'b1, 8'hF6, 8'hA5);
    apb(1'b1, 8'hF8, 8'hFF);
    apb(1'b1, 8'hF9, 8'h96);
    rdc(8'hF5, 8'h5A);
    rdc(8'hF8, 8'h7F);
    rdc(8'hF9, 8'h16);
    chk(AVG_DEPTH_OUT, 8'h5A);
    chk(DEBOUNCE_DUR_OUT, 8'hA5);
    chk(TRANSIENT_THR_OUT, 7'h7F);
    chk(NOISE_THR_OUT, 7'h16);
    apb(1'b1, 8'hE1, 8'h03);
    @(posedge CLK_IN);
    NOISE_EVT_IN <= 1'b1;
    TRANSIENT_EVT_IN <= 1'b1;
    @(posedge CLK_IN);
    NOISE_EVT_IN <= 1'b0;
    TRANSIENT_EVT_IN <= 1'b0;
    rdc(8'hF0, 8'h03);
    chk(IRQ_OUT, 1'b1);
    apb(1'b1, 8'hF0, 8'h00);
    apb(1'b1, 8'hE0, 8'h03);
    rdc(8'hF0, 8'h00);
    smp(1, 1'b0);
    chk(IRQ_OUT, 1'b0);
    for (int e = 0; e < 2; e++)
    begin
      @(posedge CLK_IN);
      MOTION_DET_IN <= 1'b1;
      MOTION_EXT_IN <= e[0];
      @(posedge CLK_IN);
      MOTION_DET_IN <= 1'b0;
      MOTION_EXT_IN <= ~e[0];
      rdc(8'hF0, {5'h01, e[0], 2'h0});
    end
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 8'hF2, {3'h0, s[1:0], 3'h0});
      // Decode lands one edge after the write; look one edge later
      repeat (2) @(posedge CLK_IN);
      chk(WIN_SEL_OUT, (s == 0) ? 0 : 1 << (s - 1));
      chk(WIN_RSVD_OUT, s == 0);
    end
    apb(1'b1, 8'hF2, 8'h60);
    for (int v = 11; v < 13; v++)
    begin
      n = ok_n;
      @(posedge CLK_IN);
      SLOPE_VALID_IN <= 1'b1;
      SLOPE_IN <= v[7:0];
      @(posedge CLK_IN);
      SLOPE_VALID_IN <= 1'b0;
      SLOPE_IN <= ~v[7:0];
      repeat (3) @(posedge CLK_IN);
      chk(ok_n - n, v >= 3 * STEP);
    end
    apb(1'b1, 8'hF0, 8'h10);
    for (int r = 0; r < 8; r += 7)
    begin
      apb(1'b1, 8'hF2, {5'h01, r[2:0]});
      n = fill_n;
      init;
      chk(fill_n - n, 1);
      n = lim_n;
      smp(3 + 2 * r, 1'b0);
      chk(lim_n - n, 0);
      smp(1, 1'b0);
      chk(lim_n - n, 1);
    end
    rdc(8'hF2, 8'h0F);
    apb(1'b1, 8'hF7, 8'h03);
    init;
    n = deb_n;
    smp(1, 1'b1);
    chk(deb_n - n, 0);
    smp(1, 1'b1);
    chk(deb_n - n, 1);
    apb(1'b1, 8'hF0, 8'h00);
    n = fill_n;
    init;
    chk(fill_n - n, 0);
    rdc(8'hF3, 8'hA5);
    rdc(8'hF4, 8'hC3);
    @(posedge CLK_IN);
    DC_VALID_IN <= 1'b1;
    DC_DATA_IN <= 16'h1E2D;
    @(posedge CLK_IN);
    DC_VALID_IN <= 1'b0;
    DC_DATA_IN <= 16'hE1D2;
    rdc(8'hFC, 8'h1E);
    rdc(8'hFD, 8'h2D);
    final_report;
  end
endmodule // tb_mer_adv_regs

bind mer_adv_regs mer_adv_regs_checker u_chk (.*);
`default_nettype wire
